// [basic_timer_modes_toggle.sv]
// Decided for this implementation: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps
module basic_timer_modes_toggle (
  input wire logic CLOCK_IN,
  input wire logic RESET_N_IN,
  input wire logic HSEL_IN,
  input wire logic [31:0] HADDR_IN,
  input wire logic [1:0] HTRANS_IN,
  input wire logic HWRITE_IN,
  input wire logic [2:0] HSIZE_IN,
  input wire logic [31:0] HWDATA_IN,
  input wire logic HREADY_IN,
  output logic [31:0] HRDATA_OUT,
  output logic HREADYOUT_OUT,
  output logic HRESP_OUT,
  input wire logic EXTERNAL_TRIGGER_INPUT_IN,
  input wire logic [timer_pkg::ITR_N-1:0] OVERFLOW_PULSES_IN,
  input wire logic MASTER_OUTPUT_IN,
  output logic TOGGLE_OUT_POSITIVE_OUT,
  output logic TOGGLE_OUT_NEGATIVE_PIN_OUT,
  output logic OVERFLOW_PULSE_OUT,
  output logic IRQ_OUT
);
  import timer_pkg::*;

  // ------------------------------------------------------------
  // reset release
  // ------------------------------------------------------------
  logic rst_meta_q;
  logic rst_n;

  // two-stage release of the asynchronous reset
  always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      rst_meta_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n <= rst_meta_q;
    end
  end

  // ------------------------------------------------------------
  // bus slave
  // ------------------------------------------------------------
  logic [CTRL_W-1:0] ctrl_q;
  logic [FLT_W-1:0] flt_sel_q;
  logic [CNT_W-1:0] reload_q;
  logic [CNT_W-1:0] cnt_q;
  logic [FLAG_W-1:0] status_q;
  logic [FLAG_W-1:0] ien_q;
  logic [SRC_W-1:0] src_sel_q;
  logic wr_pend_q;
  logic [ADDR_W-1:0] wr_addr_q;
  logic [31:0] rdata_q;
  logic hready_q;
  logic hresp_q;

  wire addr_ok = HSEL_IN && HTRANS_IN[1] && HREADY_IN;
  wire [ADDR_W-1:0] a_addr = HADDR_IN[ADDR_W-1:0];
  wire wr_ctrl = wr_pend_q && (wr_addr_q == OFS_CTRL);
  wire wr_adv = wr_pend_q && (wr_addr_q == OFS_ADV);
  wire wr_reload = wr_pend_q && (wr_addr_q == OFS_RELOAD);
  wire wr_cnt = wr_pend_q && (wr_addr_q == OFS_COUNT);
  wire wr_ien = wr_pend_q && (wr_addr_q == OFS_IEN);
  wire wr_clear = wr_pend_q && (wr_addr_q == OFS_CLEAR);
  wire wr_tsrc = wr_pend_q && (wr_addr_q == OFS_TSRC);

  // read mux, unmapped addresses read zero
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = ZERO_WORD;
    unique case (a_addr)
      OFS_CTRL: rd_mux[CTRL_W-1:0] = ctrl_q;
      OFS_ADV: rd_mux[FLT_W-1:0] = flt_sel_q;
      OFS_RELOAD: rd_mux[CNT_W-1:0] = reload_q;
      OFS_COUNT: rd_mux[CNT_W-1:0] = cnt_q;
      OFS_STATUS: rd_mux[FLAG_W-1:0] = status_q;
      OFS_IEN: rd_mux[FLAG_W-1:0] = ien_q;
      OFS_CLEAR: rd_mux[FLAG_W-1:0] = {FLAG_W{1'b1}};
      OFS_TSRC: rd_mux[SRC_W-1:0] = src_sel_q;
      default: rd_mux = ZERO_WORD;
    endcase
  end

  // address phase capture, zero wait state, always okay
  always_ff @(posedge CLOCK_IN or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= '0;
      rdata_q <= ZERO_WORD;
      hready_q <= 1'b1;
      hresp_q <= 1'b0;
    end else begin
      wr_pend_q <= addr_ok && HWRITE_IN;
      wr_addr_q <= a_addr;
      rdata_q <= (addr_ok && !HWRITE_IN) ? rd_mux : rdata_q;
      hready_q <= 1'b1;
      hresp_q <= 1'b0;
    end
  end

  // plain configuration registers
  always_ff @(posedge CLOCK_IN or negedge rst_n) begin
    if (!rst_n) begin
      flt_sel_q <= '0;
      reload_q <= RELOAD_RST;
      ien_q <= '0;
      src_sel_q <= '0;
    end else begin
      if (wr_adv) flt_sel_q <= HWDATA_IN[FLT_W-1:0];
      if (wr_reload) reload_q <= HWDATA_IN[CNT_W-1:0];
      if (wr_ien) ien_q <= HWDATA_IN[FLAG_W-1:0];
      if (wr_tsrc) src_sel_q <= HWDATA_IN[SRC_W-1:0];
    end
  end

  // ------------------------------------------------------------
  // external trigger filter and polarity
  // ------------------------------------------------------------
  logic etr_raw_q;
  logic etr_flt_q;
  logic etr_flt_prev_q;
  logic [FLT_W-1:0] flt_cnt_q;

  wire polarity_select = ctrl_q[B_POL];
  wire flt_take = (etr_raw_q != etr_flt_q) && (flt_cnt_q >= flt_sel_q);
  wire gate_act = etr_flt_q ^ polarity_select;
  wire etr_edge = (etr_flt_q != etr_flt_prev_q) && (etr_flt_q ^ polarity_select);

  // level must hold flt_sel+1 samples before it is passed on
  always_ff @(posedge CLOCK_IN or negedge rst_n) begin
    if (!rst_n) begin
      etr_raw_q <= 1'b0;
      etr_flt_q <= 1'b0;
      etr_flt_prev_q <= 1'b0;
      flt_cnt_q <= '0;
    end else begin
      etr_raw_q <= EXTERNAL_TRIGGER_INPUT_IN;
      etr_flt_prev_q <= etr_flt_q;
      if (flt_take) etr_flt_q <= etr_raw_q;
      if (etr_raw_q == etr_flt_q || flt_take) begin
        flt_cnt_q <= '0;
      end else begin
        flt_cnt_q <= flt_cnt_q + 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // trigger source selection
  // ------------------------------------------------------------
  wire [ITR_N:0] itr_all = {MASTER_OUTPUT_IN, OVERFLOW_PULSES_IN};
  wire itr_evt = itr_all[src_sel_q];
  wire trs_evt = ctrl_q[B_TRS] ? itr_evt : etr_edge;

  // ------------------------------------------------------------
  // mode decode and run condition
  // ------------------------------------------------------------
  mode_t mode;
  assign mode = mode_t'(ctrl_q[B_MODE_HI:B_MODE_LO]);
  wire en = ctrl_q[B_EN];
  wire trig_hit = (mode == MODE_TRIG_START) && trs_evt;
  logic run;
  logic src_evt;
  always_comb begin
    run = en;
    src_evt = 1'b1;
    unique case (mode)
      MODE_TIMER: src_evt = 1'b1;
      MODE_COUNTER: src_evt = trs_evt;
      MODE_TRIG_START: src_evt = 1'b1;
      MODE_GATED: run = en && gate_act;
    endcase
  end

  // ------------------------------------------------------------
  // prescaler and counter
  // ------------------------------------------------------------
  logic [PRS_W-1:0] prs_act_q;
  logic [PRE_W-1:0] pre_q;
  logic en_prev_q;
  logic ov_q;

  wire en_rise = en && !en_prev_q;
  // new prescale is already in force in the cycle that enable rises
  wire [PRS_W-1:0] prs_use = en_rise ? ctrl_q[B_PRS_HI:B_PRS_LO] : prs_act_q;
  wire [PRE_W-1:0] pre_lim = PRE_W'((16'h0001 << prs_use) - 16'h0001);
  wire tick = run && src_evt && (pre_q == pre_lim);
  wire ovf = tick && (cnt_q == reload_q);
  wire wrap = tick && (cnt_q > reload_q); // reload shrank below count
  wire oneshot_stop = ovf && ctrl_q[B_ONESHOT];

  // prescale change takes effect at overflow or enable rise
  always_ff @(posedge CLOCK_IN or negedge rst_n) begin
    if (!rst_n) begin
      prs_act_q <= '0;
      pre_q <= '0;
      en_prev_q <= 1'b0;
    end else begin
      en_prev_q <= en;
      if (ovf || en_rise) prs_act_q <= ctrl_q[B_PRS_HI:B_PRS_LO];
      if (!en || tick) begin // prescaler rests at zero while disabled
        pre_q <= '0;
      end else if (run && src_evt) begin
        pre_q <= pre_q + 1'b1;
      end
    end
  end

  // count register, software write wins over counting
  always_ff @(posedge CLOCK_IN or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
      ov_q <= 1'b0;
    end else begin
      ov_q <= ovf;
      if (wr_cnt) begin
        cnt_q <= HWDATA_IN[CNT_W-1:0];
      end else if (ovf || wrap) begin
        cnt_q <= '0;
      end else if (tick) begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // control register with hardware enable set and clear
  // ------------------------------------------------------------
  logic [CTRL_W-1:0] ctrl_d;
  always_comb begin
    ctrl_d = wr_ctrl ? HWDATA_IN[CTRL_W-1:0] : ctrl_q;
    if (oneshot_stop) ctrl_d[B_EN] = 1'b0;
    if (trig_hit) ctrl_d[B_EN] = 1'b1;
  end

  always_ff @(posedge CLOCK_IN or negedge rst_n) begin
    if (!rst_n) ctrl_q <= CTRL_RST;
    else ctrl_q <= ctrl_d;
  end

  // ------------------------------------------------------------
  // status flags, hardware set wins over software clear
  // ------------------------------------------------------------
  logic [FLAG_W-1:0] flag_set;
  logic [FLAG_W-1:0] flag_clr;
  assign flag_set = {trig_hit, ov_q};
  assign flag_clr = wr_clear ? ~HWDATA_IN[FLAG_W-1:0] : '0;
  wire [FLAG_W-1:0] status_d_w = (status_q & ~flag_clr) | flag_set;

  always_ff @(posedge CLOCK_IN or negedge rst_n) begin
    if (!rst_n) status_q <= '0;
    else status_q <= (status_q & ~flag_clr) | flag_set;
  end

  // ------------------------------------------------------------
  // toggle outputs and exported pulse
  // ------------------------------------------------------------
  logic tog_q;
  logic pos_q;
  logic neg_q;
  logic irq_q;
  wire toggle_output_enable = ctrl_q[B_TOGGLE_OUTPUT_ENABLE];
  wire tog_d = !toggle_output_enable ? 1'b1 : (ov_q ? !tog_q : tog_q);

  always_ff @(posedge CLOCK_IN or negedge rst_n) begin
    if (!rst_n) begin
      tog_q <= 1'b1;
      pos_q <= 1'b0;
      neg_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      tog_q <= tog_d;
      pos_q <= toggle_output_enable && tog_d;
      neg_q <= toggle_output_enable && !tog_d;
      irq_q <= |(status_d_w & ien_q);
    end
  end

  assign HRDATA_OUT = rdata_q;
  assign HREADYOUT_OUT = hready_q;
  assign HRESP_OUT = hresp_q;
  assign TOGGLE_OUT_POSITIVE_OUT = pos_q;
  assign TOGGLE_OUT_NEGATIVE_PIN_OUT = neg_q;
  assign OVERFLOW_PULSE_OUT = ov_q;
  assign IRQ_OUT = irq_q;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  property p_tog_off;
    @(posedge CLOCK_IN) disable iff (!rst_n)
      !toggle_output_enable |=> !pos_q && !neg_q;
  endproperty
  a_tog_off: assert property (p_tog_off)
    else $error("toggle pins not low while disabled");

  property p_tog_opp;
    @(posedge CLOCK_IN) disable iff (!rst_n)
      toggle_output_enable |=> pos_q != neg_q;
  endproperty
  a_tog_opp: assert property (p_tog_opp)
    else $error("toggle pins not opposite");

  property p_tog_start;
    @(posedge CLOCK_IN) disable iff (!rst_n)
      $rose(toggle_output_enable) |=> pos_q;
  endproperty
  a_tog_start: assert property (p_tog_start)
    else $error("positive pin not high on enable");

  property p_tog_flip;
    @(posedge CLOCK_IN) disable iff (!rst_n)
      ov_q && toggle_output_enable && $past(toggle_output_enable) |=> pos_q != $past(pos_q);
  endproperty
  a_tog_flip: assert property (p_tog_flip)
    else $error("toggle pins did not flip on overflow");

  property p_ov_pulse;
    @(posedge CLOCK_IN) disable iff (!rst_n)
      ov_q && reload_q != '0 |=> !ov_q;
  endproperty
  a_ov_pulse: assert property (p_ov_pulse)
    else $error("overflow pulse longer than one cycle");

  property p_ov_flag;
    @(posedge CLOCK_IN) disable iff (!rst_n)
      ovf |-> ##2 status_q[F_OV];
  endproperty
  a_ov_flag: assert property (p_ov_flag)
    else $error("overflow flag not set");

  property p_trig;
    @(posedge CLOCK_IN) disable iff (!rst_n)
      trig_hit |=> en && status_q[F_TRIG];
  endproperty
  a_trig: assert property (p_trig)
    else $error("trigger did not set enable and flag");

  property p_gate_hold;
    @(posedge CLOCK_IN) disable iff (!rst_n)
      mode == MODE_GATED && !gate_act && !wr_cnt |=> $stable(cnt_q);
  endproperty
  a_gate_hold: assert property (p_gate_hold)
    else $error("count moved with gate inactive");

  property p_timer_step;
    @(posedge CLOCK_IN) disable iff (!rst_n)
      mode == MODE_TIMER && en && prs_act_q == '0 && !en_rise
      && cnt_q < reload_q && !wr_cnt |=> cnt_q == $past(cnt_q) + 1'b1;
  endproperty
  a_timer_step: assert property (p_timer_step)
    else $error("timer did not step each clock");

  property p_halt;
    @(posedge CLOCK_IN) disable iff (!rst_n)
      !en && !wr_cnt |=> $stable(cnt_q);
  endproperty
  a_halt: assert property (p_halt)
    else $error("count moved while disabled");
endmodule : basic_timer_modes_toggle

// [test_basic_timer_modes_toggle.sv]
`timescale 1ns/1ps
// ----------------------------------------
// bench for the basic timer
// ----------------------------------------
module test_basic_timer_modes_toggle;
  import timer_pkg::*;
  typedef struct {
    logic [7:0] a;
    logic [31:0] w;
    logic [31:0] e;
  } row_t;
  logic clk, rst_n, hsel, hwrite, hready, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic pin, master, tog_p, tog_n, ov, irq, p0;
  logic [6:0] pulses;
  logic [15:0] c1;
  int fails, comparisons, n;
  row_t rows[10];

  basic_timer_modes_toggle dut (
    .CLOCK_IN(clk), .RESET_N_IN(rst_n), .HSEL_IN(hsel),
    .HADDR_IN(haddr), .HTRANS_IN(htrans), .HWRITE_IN(hwrite),
    .HSIZE_IN(hsize), .HWDATA_IN(hwdata), .HREADY_IN(hready),
    .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready), .HRESP_OUT(hresp),
    .EXTERNAL_TRIGGER_INPUT_IN(pin), .OVERFLOW_PULSES_IN(pulses),
    .MASTER_OUTPUT_IN(master), .TOGGLE_OUT_POSITIVE_OUT(tog_p),
    .TOGGLE_OUT_NEGATIVE_PIN_OUT(tog_n), .OVERFLOW_PULSE_OUT(ov),
    .IRQ_OUT(irq)
  );
  trigger_partner far (
    .clk_in(clk), .pin_out(pin), .pulses_out(pulses),
    .master_out(master)
  );

  // compare and count
  task automatic check(input logic [31:0] s, input logic [31:0] e,
                       input string m);
    comparisons++;
    if (s !== e) begin
      fails++;
      $display("wrong value at %0t: %s seen %h want %h", $time, m, s, e);
    end
  endtask : check

  // one single ahb-lite transfer, waits on hready
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h000000, a};
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    r = hrdata;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, rd);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] e,
                     input string m);
    bus(1'b0, a, ZERO_WORD, rd);
    check(rd, e, m);
  endtask : rdc

  // waits for the next overflow pulse
  task automatic wait_ov();
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ov !== 1'b1 && n < 200);
  endtask : wait_ov

  task automatic results();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : results

  // clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // watchdog
  initial begin
    repeat (40000) @(posedge clk);
    fails++;
    results();
  end

  // main sequence
  initial begin
    rst_n = 1'b0;
    hsel = 1'b0;
    haddr = ZERO_WORD;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = ZERO_WORD;
    rows = '{'{OFS_CTRL, 32'h0000_0F38, 32'h0000_0F38},
      '{OFS_ADV, 32'h0000_00FF, 32'h0000_0007},
      '{OFS_RELOAD, 32'h1234_ABCD, 32'h0000_ABCD},
      '{OFS_COUNT, 32'h0000_0005, 32'h0000_0005},
      '{OFS_STATUS, 32'h0000_0003, ZERO_WORD},
      '{OFS_IEN, 32'h0000_0003, 32'h0000_0003},
      '{OFS_CLEAR, ZERO_WORD, 32'h0000_0003},
      '{OFS_TSRC, 32'h0000_00FF, 32'h0000_0007},
      '{8'h20, 32'hFFFF_FFFF, ZERO_WORD},
      '{OFS_CTRL, ZERO_WORD, ZERO_WORD}};
    repeat (16) @(posedge clk);
    check({28'h0, tog_p, tog_n, ov, irq}, ZERO_WORD, "reset pins");
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rdc(OFS_RELOAD, 32'h0000_FFFF, "reload reset");
    rdc(OFS_CTRL, ZERO_WORD, "ctrl reset");
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      rdc(rows[i].a, rows[i].e, "register");
    end
    check({31'h0, hresp}, ZERO_WORD, "response");
    // timer mode, prescale 2, reload 3, toggle and irq
    wr(OFS_RELOAD, 32'h3);
    wr(OFS_COUNT, ZERO_WORD);
    wr(OFS_IEN, 32'h1);
    wr(OFS_CTRL, 32'h0000_0111);
    repeat (2) @(posedge clk);
    check({30'h0, tog_p, tog_n}, 32'h2, "toggle start");
    wait_ov();
    // one period of 2 x (3 + 1) clocks, plus the registered pulse
    check(32'(n + 2), 32'h9, "first period");
    repeat (3) @(posedge clk);
    p0 = tog_p;
    wait_ov();
    check(32'(n + 3), 32'h8, "period");
    @(posedge clk);
    check({31'h0, ov}, ZERO_WORD, "pulse width");
    repeat (2) @(posedge clk);
    check({30'h0, tog_p, tog_n}, {30'h0, ~p0, p0}, "flip");
    check({31'h0, irq}, 32'h1, "irq");
    rdc(OFS_STATUS, 32'h1, "ov flag");
    wr(OFS_CTRL, 32'h0000_0010);
    wr(OFS_CLEAR, 32'h2);
    rdc(OFS_STATUS, ZERO_WORD, "ov clear");
    check({31'h0, irq}, ZERO_WORD, "irq off");
    wr(OFS_CTRL, ZERO_WORD);
    repeat (2) @(posedge clk);
    check({30'h0, tog_p, tog_n}, ZERO_WORD, "toggle off");
    // one-shot, no prescale: enable drops at the first overflow
    wr(OFS_COUNT, ZERO_WORD);
    wr(OFS_CTRL, 32'h9);
    repeat (12) @(posedge clk);
    rdc(OFS_CTRL, 32'h8, "one-shot stop");
    rdc(OFS_COUNT, ZERO_WORD, "one-shot count");
    rdc(OFS_STATUS, 32'h1, "one-shot flag");
    wr(OFS_CLEAR, 32'h2);
    // counter mode on each internal source, prescale 2
    wr(OFS_RELOAD, 32'h0000_FFFF);
    for (int c = 0; c < 8; c++) begin
      wr(OFS_TSRC, 32'(c));
      wr(OFS_COUNT, ZERO_WORD);
      wr(OFS_CTRL, 32'h0000_0123);
      repeat (4) begin
        far.pulse(c);
        far.pulse((c + 1) % 8);
      end
      rdc(OFS_COUNT, 32'h2, "itr count");
      wr(OFS_CTRL, ZERO_WORD);
    end
    // counter mode on filtered pin edges, both polarities
    wr(OFS_ADV, 32'h2);
    for (int p = 0; p < 2; p++) begin
      far.pin(p[0], 6);
      wr(OFS_COUNT, ZERO_WORD);
      wr(OFS_CTRL, 32'(32'h3 | (p << 6)));
      repeat (3) begin
        far.pin(~p[0], 5);
        far.pin(p[0], 5);
      end
      far.pin(~p[0], 1);
      far.pin(p[0], 6);
      rdc(OFS_COUNT, 32'h3, "pin edges");
      wr(OFS_CTRL, ZERO_WORD);
    end
    // trigger start from a rising pin edge, halt and resume
    far.pin(1'b0, 6);
    wr(OFS_COUNT, ZERO_WORD);
    wr(OFS_CTRL, 32'h4);
    rdc(OFS_COUNT, ZERO_WORD, "no start");
    far.pin(1'b1, 8);
    rdc(OFS_CTRL, 32'h5, "hw enable");
    rdc(OFS_STATUS, 32'h2, "trig flag");
    wr(OFS_CTRL, 32'h4);
    bus(1'b0, OFS_COUNT, ZERO_WORD, rd);
    c1 = rd[15:0];
    check({31'h0, c1 != 16'h0}, 32'h1, "started");
    repeat (10) @(posedge clk);
    rdc(OFS_COUNT, {16'h0, c1}, "halted");
    wr(OFS_CTRL, 32'h5);
    repeat (10) @(posedge clk);
    bus(1'b0, OFS_COUNT, ZERO_WORD, rd);
    check({31'h0, rd[15:0] > c1}, 32'h1, "resumed");
    // trigger start from an internal source
    wr(OFS_TSRC, 32'h3);
    wr(OFS_CTRL, 32'h24);
    far.pulse(3);
    rdc(OFS_CTRL, 32'h25, "itr start");
    wr(OFS_CTRL, ZERO_WORD);
    // gated mode, both gate levels
    for (int p = 0; p < 2; p++) begin
      far.pin(p[0], 6);
      wr(OFS_COUNT, ZERO_WORD);
      wr(OFS_CTRL, 32'(32'h7 | (p << 6)));
      repeat (6) @(posedge clk);
      rdc(OFS_COUNT, ZERO_WORD, "gate shut");
      far.pin(~p[0], 10);
      bus(1'b0, OFS_COUNT, ZERO_WORD, rd);
      check({31'h0, rd[15:0] > 16'h3}, 32'h1, "gate open");
      far.pin(p[0], 6);
      bus(1'b0, OFS_COUNT, ZERO_WORD, rd);
      c1 = rd[15:0];
      repeat (8) @(posedge clk);
      rdc(OFS_COUNT, {16'h0, c1}, "frozen");
      wr(OFS_CTRL, ZERO_WORD);
    end
    // reset with toggle output on and counter disabled: pins drop at once, registers return to reset
    wr(OFS_RELOAD, 32'h3);
    wr(OFS_CTRL, 32'h10);
    repeat (2) @(posedge clk);
    check({30'h0, tog_p, tog_n}, 32'h2, "before reset");
    rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    check({28'h0, tog_p, tog_n, ov, irq}, ZERO_WORD, "mid reset");
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rdc(OFS_RELOAD, 32'h0000_FFFF, "reload after reset");
    rdc(OFS_CTRL, ZERO_WORD, "ctrl after reset");
    results();
  end
endmodule : test_basic_timer_modes_toggle

// [timer_pkg.sv]
package timer_pkg;
  // ------------------------------------------------------------
  // register map (byte addresses)
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00; // basic_control_reg
  localparam logic [7:0] OFS_ADV = 8'h04; // advanced_control_reg
  localparam logic [7:0] OFS_RELOAD = 8'h08; // reload_value
  localparam logic [7:0] OFS_COUNT = 8'h0C; // count_value
  localparam logic [7:0] OFS_STATUS = 8'h10; // status_flags_reg
  localparam logic [7:0] OFS_IEN = 8'h14; // interrupt_enable_reg
  localparam logic [7:0] OFS_CLEAR = 8'h18; // flag_clear_reg
  localparam logic [7:0] OFS_TSRC = 8'h1C; // trigger_source_select_reg
  localparam int ADDR_W = 8;
  // ------------------------------------------------------------
  // control field layout
  // ------------------------------------------------------------
  localparam int CTRL_W = 12;
  localparam int B_EN = 0;
  localparam int B_MODE_LO = 1;
  localparam int B_MODE_HI = 2;
  localparam int B_ONESHOT = 3;
  localparam int B_TOGGLE_OUTPUT_ENABLE = 4;
  localparam int B_TRS = 5;
  localparam int B_POL = 6;
  localparam int B_PRS_LO = 8;
  localparam int B_PRS_HI = 11;
  localparam int PRS_W = 4;
  localparam int FLT_W = 3;
  localparam int SRC_W = 3;
  localparam int CNT_W = 16;
  localparam int PRE_W = 15;
  localparam int ITR_N = 7;
  // status / enable / clear flag positions
  localparam int FLAG_W = 2;
  localparam int F_OV = 0;
  localparam int F_TRIG = 1;
  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [CTRL_W-1:0] CTRL_RST = 12'h000;
  localparam logic [CNT_W-1:0] RELOAD_RST = 16'hFFFF;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
  // itr code that picks the advanced timer master output
  localparam logic [SRC_W-1:0] SRC_MASTER = 3'h7;
  // operating modes, in field order 00..11
  typedef enum logic [1:0] {
    MODE_TIMER,
    MODE_COUNTER,
    MODE_TRIG_START,
    MODE_GATED
  } mode_t;
endpackage : timer_pkg

// [trigger_partner.sv]
`timescale 1ns/1ps
// ----------------------------------------
// far side: other timers and shared pin
// ----------------------------------------
module trigger_partner (
  input wire logic clk_in,
  output logic pin_out,
  output logic [6:0] pulses_out,
  output logic master_out
);
  // idle levels: pin low, no pulses
  initial begin
    pin_out = 1'b0;
    pulses_out = 7'h00;
    master_out = 1'b0;
  end
  // one-cycle pulse on the source of a code, never this timer's own
  task automatic pulse(input int code);
    @(posedge clk_in);
    if (code == 7) master_out <= 1'b1;
    else pulses_out[code] <= 1'b1;
    @(posedge clk_in);
    master_out <= 1'b0;
    pulses_out <= 7'h00;
    @(posedge clk_in);
  endtask : pulse
  // shared external pin, level held for n cycles
  task automatic pin(input logic lvl, input int n);
    @(posedge clk_in);
    pin_out <= lvl;
    repeat (n) @(posedge clk_in);
  endtask : pin
endmodule : trigger_partner
